// ===== core/utx_regs.svh
/*
 Register offsets, field positions, reset values and timing counts of the serial transceiver.
 Assumes inclusion by bare name from any design file of the block.
*/
`ifndef UTX_REGS_SVH
`define UTX_REGS_SVH

`define UTX_OFS_STATUS 4'h0
`define UTX_OFS_CONTROL 4'h4
`define UTX_OFS_FORMAT 4'h8
`define UTX_OFS_DATA 4'hc
`define UTX_OFS_BAUD 4'h0
`define UTX_BAUD_WORD 8'h10

`define UTX_ST_RXC 7
`define UTX_ST_TXC 6
`define UTX_ST_UDRE 5

`define UTX_CT_TXCIE 6
`define UTX_CT_UDRIE 5
`define UTX_CT_RXEN 4
`define UTX_CT_TRANSMITTER_ENABLE_BIT 3
`define UTX_CT_TX9 0

`define UTX_FM_SYNC 6
`define UTX_FM_PEN 5
`define UTX_FM_PODD 4
`define UTX_FM_STOP2 3
`define UTX_FM_SIZE_HI 2
`define UTX_FM_SIZE_LO 0

`define UTX_SIZE_9 3'h7
`define UTX_FORMAT_RST 8'h06
`define UTX_BAUD_RST 16'h0081
`define UTX_OVERSAMPLE 4'hf
`define UTX_MID_SAMPLE 4'h7

`endif

// ===== core/utx_pkg.sv
/*
 Types shared by the transceiver files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package utx_pkg;
   typedef enum logic [2:0] {
      UTX_IDLE = 3'b000,
      UTX_START = 3'b001,
      UTX_DATA = 3'b010,
      UTX_PARITY = 3'b011,
      UTX_STOP = 3'b100
   } utx_phase_t;
endpackage

// ===== core/utx_tick_if.sv
/*
 Interface carrying the bit-timing enables from the divider to the core.
 Assumes one clock domain.
*/
`timescale 1ns/10ps
interface utx_tick_if;
   logic [15:0] divisor;
   logic tick;
   logic sync_rise;
   logic sync_fall;
   logic sync_mode;
   modport gen (input divisor, input sync_mode, output tick, output sync_rise, output sync_fall);
   modport use_side (output divisor, output sync_mode, input tick, input sync_rise, input sync_fall);
endinterface

// ===== core/utx_tick.sv
/*
 Oversample enable divider plus edge detector for the external transfer clock.
 Assumes the transfer clock input is already synchronised by two flip-flops.
*/
`timescale 1ns/10ps
module utx_tick
   import utx_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic xck_sync,
   utx_tick_if.gen tk
);
   logic [15:0] count;
   logic xck_last;
   wire wrap = (count == 16'h0000);
   wire [15:0] next_count = wrap ? tk.divisor : count - 16'h0001;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         count <= 16'h0000;
         xck_last <= 1'b0;
      end
      else
      begin
         count <= next_count;
         xck_last <= xck_sync;
      end
   end

   assign tk.tick = wrap;
   assign tk.sync_rise = tk.sync_mode & xck_sync & ~xck_last;
   assign tk.sync_fall = tk.sync_mode & ~xck_sync & xck_last;
endmodule

// ===== core/utx_core.sv
/*
 Serial transceiver: transmit buffer, flags and interrupt requests, parity, deferred
 transmitter disable with pin release, and receive front end with receive buffer, behind AXI4-Lite.
 Assumes one 20 MHz clock, synchronous active-low reset, and a port mux outside that
 takes the OE outputs as pin-ownership selects.
*/
`timescale 1ns/10ps
`include "utx_regs.svh"

module utx_core
   import utx_pkg::*;
#(
   parameter logic [15:0] BAUD_DIV = `UTX_BAUD_RST
)
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [3:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [3:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic TXC_IRQ_ACK,
   output logic TX_EMPTY_IRQ,
   output logic TX_COMPLETE_IRQ,
   output logic SERIAL_OUT_PIN,
   output logic SERIAL_OUT_OE,
   input wire logic SERIAL_IN_PIN,
   output logic SERIAL_IN_OWNED,
   input wire logic SYNC_CLOCK_PIN
);
   // Control and format registers
   logic [7:0] line_control_reg;
   logic [7:0] frame_format_reg;
   logic [15:0] baud_divisor_reg;
   logic tx_buffer_empty_flag;
   logic tx_complete_flag;
   logic rx_complete_flag;
   logic [8:0] tx_buffer;
   logic [8:0] rx_buffer;

   // Input synchronisers
   logic rx_meta, rx_sync, xck_meta, xck_sync;

   // AXI write side
   logic aw_held, w_held;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // Transmitter
   utx_phase_t tx_phase;
   logic [8:0] tx_shift;
   logic [3:0] tx_sub;
   logic [3:0] tx_bitn;
   logic tx_par;
   logic tx_stop2;
   logic tx_active;

   // Receiver
   utx_phase_t rx_phase;
   logic [8:0] rx_shift;
   logic [3:0] rx_sub;
   logic [3:0] rx_bitn;

   utx_tick_if tk();

   utx_tick u_tick
   (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .xck_sync(xck_sync),
      .tk(tk)
   );

   wire sync_mode = frame_format_reg[`UTX_FM_SYNC];
   assign tk.divisor = baud_divisor_reg;
   assign tk.sync_mode = sync_mode;

   wire [2:0] size_code = frame_format_reg[`UTX_FM_SIZE_HI:`UTX_FM_SIZE_LO];
   wire nine_bit = (size_code == `UTX_SIZE_9);
   wire [3:0] data_bits = nine_bit ? 4'h9 : (size_code > 3'h3 ? 4'h8 : 4'h5 + {2'h0, size_code[1:0]});
   wire [8:0] size_mask = ~(9'h1ff << data_bits);

   // Bus decode
   wire do_write = aw_held & w_held & ~S_AXI_BVALID;
   wire do_read = S_AXI_ARVALID & S_AXI_ARREADY;
   wire wr_status = do_write & (aw_addr == `UTX_OFS_STATUS) & w_strb[0];
   wire wr_control = do_write & (aw_addr == `UTX_OFS_CONTROL) & w_strb[0];
   wire wr_format = do_write & (aw_addr == `UTX_OFS_FORMAT) & w_strb[0];
   wire wr_data = do_write & (aw_addr == `UTX_OFS_DATA) & w_strb[0];
   wire wr_baud = do_write & (aw_addr == `UTX_OFS_FORMAT) & (w_strb[3:2] != 2'h0);
   wire rd_data = do_read & (S_AXI_ARADDR == `UTX_OFS_DATA);

   // Bit timing enables
   wire tx_tick = sync_mode ? tk.sync_fall : tk.tick;
   wire tx_bit_end = sync_mode ? tk.sync_fall : (tk.tick & (tx_sub == `UTX_OVERSAMPLE));
   wire rx_sample = sync_mode ? tk.sync_rise : (tk.tick & (rx_sub == `UTX_MID_SAMPLE));
   wire rx_tick = sync_mode ? tk.sync_rise : tk.tick;

   // Transmit path
   wire tx_enable = line_control_reg[`UTX_CT_TRANSMITTER_ENABLE_BIT];
   wire tx_idle = (tx_phase == UTX_IDLE);
   wire tx_last_stop = (tx_phase == UTX_STOP) & tx_bit_end & ~tx_stop2;
   // Buffer held while disabled, so a late enable still sends it
   wire tx_load = ~tx_buffer_empty_flag & tx_active & (tx_idle | tx_last_stop);
   wire tx_done = tx_last_stop & tx_buffer_empty_flag;
   wire tx_still_busy = ~tx_idle | ~tx_buffer_empty_flag;
   wire next_tx_active = tx_enable | (tx_active & tx_still_busy);
   wire [8:0] tx_word = tx_buffer & size_mask;
   wire tx_parity = (^tx_word) ^ frame_format_reg[`UTX_FM_PODD];
   wire tx_line = (tx_phase == UTX_START) ? 1'b0 :
                  (tx_phase == UTX_DATA) ? tx_shift[0] :
                  (tx_phase == UTX_PARITY) ? tx_par : 1'b1;

   // Receive path
   wire rx_enable = line_control_reg[`UTX_CT_RXEN];
   wire rx_in = rx_enable ? rx_sync : 1'b1;
   wire rx_first_stop = (rx_phase == UTX_STOP) & rx_sample;
   wire [8:0] rx_aligned = rx_shift >> (4'h9 - data_bits);

   wire [7:0] status_view = {rx_complete_flag, tx_complete_flag, tx_buffer_empty_flag, 5'h00};
   wire [31:0] read_mux = (S_AXI_ARADDR == `UTX_OFS_STATUS) ? {24'h0, status_view} :
                          (S_AXI_ARADDR == `UTX_OFS_CONTROL) ?
                             {23'h0, rx_buffer[8], line_control_reg[7:1], line_control_reg[0]} :
                          (S_AXI_ARADDR == `UTX_OFS_FORMAT) ? {baud_divisor_reg, 8'h0, frame_format_reg} :
                          {24'h0, rx_buffer[7:0]};

   // Synchronisers
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         xck_meta <= 1'b0;
         xck_sync <= 1'b0;
      end
      else
      begin
         rx_meta <= SERIAL_IN_PIN;
         rx_sync <= rx_meta;
         xck_meta <= SYNC_CLOCK_PIN;
         xck_sync <= xck_meta;
      end
   end

   // AXI write channel capture; address and data in either order
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         S_AXI_BVALID <= 1'b0;
      end
      else
      begin
         if (S_AXI_AWVALID & S_AXI_AWREADY)
         begin
            aw_held <= 1'b1;
            aw_addr <= {S_AXI_AWADDR[3:2], 2'h0};
         end
         if (S_AXI_WVALID & S_AXI_WREADY)
         begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID <= 1'b1;
         end
         else if (S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
      end
   end

   assign S_AXI_AWREADY = RST_N & ~aw_held & ~S_AXI_BVALID;
   assign S_AXI_WREADY = RST_N & ~w_held & ~S_AXI_BVALID;
   assign S_AXI_BRESP = 2'h0;

   // AXI read channel
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
      end
      else
      begin
         S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
         if (do_read)
         begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= read_mux;
         end
         else if (S_AXI_RREADY)
            S_AXI_RVALID <= 1'b0;
      end
   end

   assign S_AXI_RRESP = 2'h0;

   // Registers and flags
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         line_control_reg <= 8'h00;
         frame_format_reg <= `UTX_FORMAT_RST;
         baud_divisor_reg <= BAUD_DIV;
         tx_buffer <= 9'h000;
         tx_buffer_empty_flag <= 1'b1;
         tx_complete_flag <= 1'b0;
      end
      else
      begin
         if (wr_control)
            line_control_reg <= w_data[7:0];
         if (wr_format)
            frame_format_reg <= w_data[7:0];
         if (wr_baud)
            baud_divisor_reg <= w_data[31:16];
         // Ninth bit sampled at the data write, so it must already be set
         if (wr_data)
         begin
            tx_buffer <= {line_control_reg[`UTX_CT_TX9], w_data[7:0]};
            tx_buffer_empty_flag <= 1'b0;
         end
         else if (tx_load)
            tx_buffer_empty_flag <= 1'b1;
         // Status writes ignore the empty flag position
         if (tx_done)
            tx_complete_flag <= 1'b1;
         else if (TXC_IRQ_ACK | (wr_status & w_data[`UTX_ST_TXC]))
            tx_complete_flag <= 1'b0;
      end
   end

   // Transmit shifter; runs only while the transmitter owns the pin
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         tx_phase <= UTX_IDLE;
         tx_shift <= 9'h000;
         tx_sub <= 4'h0;
         tx_bitn <= 4'h0;
         tx_par <= 1'b0;
         tx_stop2 <= 1'b0;
         tx_active <= 1'b0;
      end
      else
      begin
         tx_active <= next_tx_active;
         if (tx_tick & ~tx_idle)
            tx_sub <= tx_sub + 4'h1;
         if (tx_load & tx_active)
         begin
            tx_phase <= UTX_START;
            tx_shift <= tx_word;
            tx_par <= tx_parity;
            tx_bitn <= 4'h0;
            tx_sub <= 4'h0;
         end
         else if (tx_bit_end)
         begin
            unique case (tx_phase)
               UTX_IDLE:
                  tx_sub <= 4'h0;
               UTX_START:
                  tx_phase <= UTX_DATA;
               UTX_DATA:
               begin
                  tx_shift <= tx_shift >> 1;
                  tx_bitn <= tx_bitn + 4'h1;
                  if (tx_bitn == data_bits - 4'h1)
                  begin
                     tx_phase <= frame_format_reg[`UTX_FM_PEN] ? UTX_PARITY : UTX_STOP;
                     tx_stop2 <= frame_format_reg[`UTX_FM_STOP2];
                  end
               end
               UTX_PARITY:
                  tx_phase <= UTX_STOP;
               UTX_STOP:
                  if (tx_stop2)
                     tx_stop2 <= 1'b0;
                  else
                     tx_phase <= UTX_IDLE;
            endcase
         end
      end
   end

   // Receive front end
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         rx_phase <= UTX_IDLE;
         rx_shift <= 9'h000;
         rx_sub <= 4'h0;
         rx_bitn <= 4'h0;
         rx_buffer <= 9'h000;
         rx_complete_flag <= 1'b0;
      end
      else
      begin
         if (rx_tick & (rx_phase != UTX_IDLE))
            rx_sub <= rx_sub + 4'h1;
         if (rx_first_stop)
         begin
            rx_buffer <= rx_aligned & size_mask;
            rx_complete_flag <= 1'b1;
         end
         else if (rd_data | ~rx_enable)
            rx_complete_flag <= 1'b0;
         unique case (rx_phase)
            UTX_IDLE:
               if (~rx_in & rx_enable & rx_tick)
               begin
                  // Sync start sampled on a clock rise already, so data follows
                  rx_phase <= sync_mode ? UTX_DATA : UTX_START;
                  rx_sub <= 4'h1;
                  rx_bitn <= 4'h0;
               end
            UTX_START:
               if (rx_sample)
                  rx_phase <= (rx_in & ~sync_mode) ? UTX_IDLE : UTX_DATA;
            UTX_DATA:
               if (rx_sample)
               begin
                  rx_shift <= {rx_in, rx_shift[8:1]};
                  rx_bitn <= rx_bitn + 4'h1;
                  if (rx_bitn == data_bits - 4'h1)
                     rx_phase <= frame_format_reg[`UTX_FM_PEN] ? UTX_PARITY : UTX_STOP;
               end
            UTX_PARITY:
               if (rx_sample)
                  rx_phase <= UTX_STOP;
            UTX_STOP:
               if (rx_sample)
                  rx_phase <= UTX_IDLE;
            default:
               rx_phase <= UTX_IDLE;
         endcase
      end
   end

   // Pin and request outputs, all registered
   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         SERIAL_OUT_PIN <= 1'b1;
         SERIAL_OUT_OE <= 1'b0;
         SERIAL_IN_OWNED <= 1'b0;
         TX_EMPTY_IRQ <= 1'b0;
         TX_COMPLETE_IRQ <= 1'b0;
      end
      else
      begin
         SERIAL_OUT_PIN <= tx_line;
         SERIAL_OUT_OE <= next_tx_active;
         SERIAL_IN_OWNED <= rx_enable;
         TX_EMPTY_IRQ <= line_control_reg[`UTX_CT_UDRIE] & tx_buffer_empty_flag;
         TX_COMPLETE_IRQ <= line_control_reg[`UTX_CT_TXCIE] & tx_complete_flag;
      end
   end
endmodule

// ===== test/utx_core_sva.sv
/*
 Checker on the transceiver top ports: reset state, line release, flag requests.
 Assumes binding into utx_core, single clock, synchronous active-low reset.
*/
`timescale 1ns/10ps
module utx_core_sva
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic S_AXI_WVALID,
   input wire logic TXC_IRQ_ACK,
   input wire logic TX_EMPTY_IRQ,
   input wire logic TX_COMPLETE_IRQ,
   input wire logic SERIAL_OUT_PIN,
   input wire logic SERIAL_OUT_OE,
   input wire logic SERIAL_IN_OWNED
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);
   // Own disable, since this one is about the reset itself
   AST_RESET_IDLE: assert property (disable iff (1'b0) !RST_N |=> !TX_EMPTY_IRQ && !TX_COMPLETE_IRQ
      && !SERIAL_OUT_OE && SERIAL_OUT_PIN && !SERIAL_IN_OWNED) else $error("reset state wrong");
   AST_PIN_RELEASED: assert property (!SERIAL_OUT_OE |-> SERIAL_OUT_PIN) else $error("released pin not idle");
   AST_EMPTY_LEVEL: assert property ($fell(TX_EMPTY_IRQ) |-> $past(S_AXI_WVALID) ||
      $past(S_AXI_WVALID, 2) || $past(S_AXI_WVALID, 3)) else $error("empty request dropped without write");
   AST_COMPLETE_CLEAR: assert property (TXC_IRQ_ACK && TX_COMPLETE_IRQ |-> ##[1:3] !TX_COMPLETE_IRQ)
      else $error("complete request kept after service");
   AST_COMPLETE_AT_IDLE: assert property ($rose(TX_COMPLETE_IRQ) |-> SERIAL_OUT_PIN &&
      $past(SERIAL_OUT_PIN, 2) && $past(SERIAL_OUT_PIN, 8)) else $error("complete before stop bit");
   AST_RX_OWN: assert property ($rose(SERIAL_IN_OWNED) |-> $past(S_AXI_WVALID) ||
      $past(S_AXI_WVALID, 2) || $past(S_AXI_WVALID, 3)) else $error("input taken without write");
   // OE may only drop after a stop bit, never mid frame
   AST_DISABLE_AFTER_STOP: assert property ($fell(SERIAL_OUT_OE) |-> $past(SERIAL_OUT_PIN) &&
      $past(SERIAL_OUT_PIN, 4) && $past(SERIAL_OUT_PIN, 8)) else $error("transmitter stopped mid frame");
   AST_BIT_LENGTH: assert property ($fell(SERIAL_OUT_PIN) |=> !SERIAL_OUT_PIN [*8])
      else $error("low bit too short");
endmodule

bind utx_core utx_core_sva u_sva (.SYS_CLK, .RST_N, .S_AXI_WVALID, .TXC_IRQ_ACK, .TX_EMPTY_IRQ,
   .TX_COMPLETE_IRQ, .SERIAL_OUT_PIN, .SERIAL_OUT_OE, .SERIAL_IN_OWNED);

// ===== test/utx_peer.sv
/*
 Peer serial device: captures frames from the transmit line, sends frames on the receive line.
 Assumes 32 clocks an asynchronous bit, 16 a synchronous one; line idles high, transfer clock idles low.
*/
`timescale 1ns/10ps
module utx_peer
#(
   parameter int BIT_CLKS = 32
)
(
   input wire logic clk,
   input wire logic line_out,
   input wire logic oe,
   output logic line_in,
   output logic sync_clk
);
   int rx_bits = 10;
   logic [11:0] got[$];
   initial
   begin
      line_in = 1'b1;
      sync_clk = 1'b0;
   end
   // Mid-bit sampling, LSB first; bits counted after start, first stop included
   always
   begin : catch_frame
      logic [11:0] f;
      @(posedge clk iff (oe && !line_out));
      f = '0;
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < rx_bits; i++)
      begin
         repeat (BIT_CLKS) @(posedge clk);
         f[i] = line_out;
      end
      got.push_back(f);
   end
   task send(input logic [11:0] bits, input int n);
      line_in <= 1'b0;
      repeat (BIT_CLKS) @(posedge clk);
      for (int i = 0; i < n; i++)
      begin
         line_in <= bits[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      line_in <= 1'b1;
   endtask
   // Synchronous send: bits include start and stop; clock idles low between frames
   task send_sync(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++)
      begin
         line_in <= bits[i];
         repeat (8) @(posedge clk);
         sync_clk <= 1'b1;
         repeat (8) @(posedge clk);
         sync_clk <= 1'b0;
      end
      line_in <= 1'b1;
   endtask
endmodule

// ===== test/utx_core_tb.sv
/*
 Bench for the transceiver: AXI4-Lite tasks, frame checks against the peer model.
 Assumes utx_core, utx_peer and the checker are compiled before it.
*/
`timescale 1ns/10ps
`include "utx_regs.svh"
module utx_core_tb;
   logic sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, ack;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rd;
   wire logic awready, wready, bvalid, arready, rvalid, irq_e, irq_c, sout, soe, sin, sown, sclk;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   int mismatches, tests_run, cycles;
   always #25 sys_clk = ~sys_clk;
   utx_core #(.BAUD_DIV(16'h0001)) DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .TXC_IRQ_ACK(ack), .TX_EMPTY_IRQ(irq_e), .TX_COMPLETE_IRQ(irq_c), .SERIAL_OUT_PIN(sout),
      .SERIAL_OUT_OE(soe), .SERIAL_IN_PIN(sin), .SERIAL_IN_OWNED(sown), .SYNC_CLOCK_PIN(sclk));
   utx_peer peer (.clk(sys_clk), .line_out(sout), .oe(soe), .line_in(sin), .sync_clk(sclk));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Address and data offered together, taken in either order
   task wr(input logic [3:0] a, input logic [31:0] d);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (aw_p || w_p)
      begin
         @(posedge sys_clk);
         if (aw_p && awready)
         begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_p && wready)
         begin
            w_p = 1'b0;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid) @(posedge sys_clk);
      chk(bresp, 2'h0);
   endtask
   // Ready lines stay high throughout, so no toggling between calls
   task rdr(input logic [3:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge sys_clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (!rvalid);
      rd = rdata;
      chk(rresp, 2'h0);
   endtask
   // Generous ceiling: seven frames of at most 384 clocks each
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   initial
   begin
      sys_clk = 0;
      {rst_n, awvalid, wvalid, bready, arvalid, rready, ack} = '0;
      {awaddr, araddr, wstrb, wdata} = '0;
      {mismatches, tests_run, cycles} = '0;
      {bready, rready} = 2'b11;
      wstrb = 4'hf;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rdr(`UTX_OFS_STATUS);
      chk(rd[7:5], 3'b001);
      chk({irq_e, irq_c, soe, sown}, 4'h0);
      rdr(`UTX_OFS_FORMAT);
      chk(rd[7:0], `UTX_FORMAT_RST);
      wr(`UTX_OFS_FORMAT, 32'h0001_0023);
      wr(`UTX_OFS_CONTROL, 32'h0000_0078);
      repeat (3) @(posedge sys_clk);
      chk(irq_e, 1'b1);
      chk(sown, 1'b1);
      wr(`UTX_OFS_DATA, 32'h0000_003c);
      wr(`UTX_OFS_DATA, 32'h0000_0007);
      rdr(`UTX_OFS_STATUS);
      chk(rd[`UTX_ST_UDRE], 1'b0);
      chk(irq_e, 1'b0);
      while (!irq_c) @(posedge sys_clk);
      chk(peer.got.size(), 2);
      chk(peer.got[0], {1'b1, ^8'h3c, 8'h3c});
      chk(peer.got[1], {1'b1, ^8'h07, 8'h07});
      rdr(`UTX_OFS_STATUS);
      chk(rd[7:5], 3'b011);
      ack <= 1'b1;
      @(posedge sys_clk);
      ack <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk(irq_c, 1'b0);
      // Nine-bit odd parity; ninth bit goes in before the low byte
      wr(`UTX_OFS_FORMAT, 32'h0001_0037);
      peer.rx_bits = 11;
      wr(`UTX_OFS_CONTROL, 32'h0000_0079);
      wr(`UTX_OFS_DATA, 32'h0000_0055);
      while (!irq_c) @(posedge sys_clk);
      chk(peer.got[2], {1'b1, ~^9'h155, 9'h155});
      wr(`UTX_OFS_STATUS, 32'h0000_0040);
      rdr(`UTX_OFS_STATUS);
      chk(rd[`UTX_ST_TXC], 1'b0);
      // Disable while a frame is on the line
      wr(`UTX_OFS_FORMAT, 32'h0001_0003);
      peer.rx_bits = 9;
      wr(`UTX_OFS_DATA, 32'h0000_00a5);
      wr(`UTX_OFS_CONTROL, 32'h0000_0070);
      repeat (20) @(posedge sys_clk);
      chk(soe, 1'b1);
      while (soe) @(posedge sys_clk);
      chk(peer.got.size(), 4);
      chk(peer.got[3], {1'b1, 8'ha5});
      chk(sout, 1'b1);
      wr(`UTX_OFS_CONTROL, 32'h0000_0050);
      repeat (3) @(posedge sys_clk);
      chk(irq_e, 1'b0);
      // Two stop bits set, peer sends only one: the first must end the frame
      wr(`UTX_OFS_FORMAT, 32'h0001_000b);
      peer.send({1'b1, 8'h5a}, 9);
      rdr(`UTX_OFS_STATUS);
      chk(rd[`UTX_ST_RXC], 1'b1);
      rdr(`UTX_OFS_DATA);
      chk(rd, 32'h0000_005a);
      wr(`UTX_OFS_FORMAT, 32'h0001_0000);
      peer.send({1'b1, 5'h15}, 6);
      repeat (4) @(posedge sys_clk);
      rdr(`UTX_OFS_DATA);
      chk(rd, 32'h0000_0015);
      // Synchronous receive on the external transfer clock
      wr(`UTX_OFS_FORMAT, 32'h0001_0043);
      peer.send_sync({1'b1, 8'hc3, 1'b0}, 10);
      repeat (4) @(posedge sys_clk);
      rdr(`UTX_OFS_DATA);
      chk(rd, 32'h0000_00c3);
      wr(`UTX_OFS_CONTROL, 32'h0000_0000);
      repeat (3) @(posedge sys_clk);
      chk(sown, 1'b0);
      end_of_test();
   end
endmodule
